// ---- hdl/hrpc_codec.sv ----
/*
 * level-3 rate parameter codec: decodes received parameter and
 * rate octets into per-set tables, encodes one range or one
 * backoff octet on command, register port and level interrupt.
 * assumes octet strobes come from logic on the same clock.
 */
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "hrpc_defs.svh"

module hrpc_codec (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // register port
    input wire logic [7:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [31:0] o_reg_rdata,
    // received octets
    input wire logic i_rx_valid,
    input wire logic [7:0] i_rx_octet,
    input wire logic i_rx_param,
    input wire logic i_rx_dir,
    input wire logic i_rx_pam32,
    // transmitted octets
    output logic o_tx_valid,
    output logic [7:0] o_tx_octet,
    output logic o_tx_param,
    input wire logic i_tx_ready,
    // interrupt
    output logic o_irq
);
    import hrpc_pkg::*;

    hrpc_state_t q;
    hrpc_state_t d;
    logic [1:0] set;
    logic [1:0] rpos;
    logic [2:0] rjdx;
    logic [3:0] ev;
    logic [3:0] clr;
    logic rx_go;
    logic cmd_wr;
    logic [6:0] dmin;
    logic [6:0] dmax;
    logic [6:0] dstep;
    logic drsv;
    logic dord;

    // octet n of a range, built from a packed {step,max,min}
    function automatic logic [7:0] enc_oct(
        input logic [20:0] r,
        input logic [1:0] p
    );
        case (p)
            2'd0: enc_oct = {5'h00, r[20], r[13], r[6]};
            2'd1: enc_oct = {2'h0, r[5:0]};
            2'd2: enc_oct = {2'h0, r[12:7]};
            default: enc_oct = {2'h0, r[19:14]};
        endcase
    endfunction

    // range decode, step octet taken live
    hrpc_range_dec u_dec (
        .i_first(q.first),
        .i_min_lo(q.mn_lo),
        .i_max_lo(q.mx_lo),
        .i_step_lo(i_rx_octet[5:0]),
        .o_min(dmin),
        .o_max(dmax),
        .o_step(dstep),
        .o_rsvd(drsv),
        .o_order_err(dord)
    );

    // stream position: a new set restarts at its first octet
    assign set = {i_rx_dir, i_rx_pam32};
    assign rpos = (set == q.cur) ? q.pos : 2'd0;
    assign rjdx = (set == q.cur) ? q.jdx : 3'd0;
    assign rx_go = q.ctl_en && i_rx_valid;
    assign cmd_wr = i_reg_wr && (i_reg_addr == `HRPC_A_TCMD);
    assign clr = (i_reg_wr && i_reg_addr == `HRPC_A_CLR) ?
        i_reg_wdata[3:0] : 4'h0;

    // next state
    always_comb begin
        d = q;
        ev = 4'h0;
        d.rdat = 32'h0000_0000;

        // register writes
        if (i_reg_wr) begin
            case (i_reg_addr)
                `HRPC_A_CTRL: d.ctl_en = i_reg_wdata[0];
                `HRPC_A_IEN: d.ien = i_reg_wdata[3:0];
                `HRPC_A_RSEL: d.rsel = i_reg_wdata[3:0];
                `HRPC_A_TRNG: d.tx_rng = i_reg_wdata[20:0];
                `HRPC_A_TPBO: d.tx_pbo = i_reg_wdata[4:0];
                default: ;
            endcase
        end

        // register reads, answered next cycle
        if (i_reg_rd) begin
            case (i_reg_addr)
                `HRPC_A_CTRL: d.rdat = {31'h0, q.ctl_en};
                `HRPC_A_STAT: d.rdat = {28'h0, q.ist};
                `HRPC_A_IEN: d.rdat = {28'h0, q.ien};
                `HRPC_A_PBO: d.rdat = {18'h0, q.pbo_us, 2'h0, q.pbo_ds};
                `HRPC_A_RSEL: d.rdat = {28'h0, q.rsel};
                `HRPC_A_RRNG: d.rdat = {5'h00, q.cnt[q.rsel[3:2]],
                    3'h0, q.tab[q.rsel]};
                `HRPC_A_TRNG: d.rdat = {11'h0, q.tx_rng};
                `HRPC_A_TPBO: d.rdat = {27'h0, q.tx_pbo};
                `HRPC_A_TCMD: d.rdat = {31'h0, q.tx_st != TX_IDLE};
                default: d.rdat = 32'h0000_0000;
            endcase
        end

        // decoder
        if (rx_go && i_rx_param) begin
            // backoff octet opens the direction's rate fields
            if (i_rx_octet[`HRPC_PBO_RSV]) begin
                ev[`HRPC_EV_RSV] = 1'b1;
            end else if (i_rx_dir) begin
                d.pbo_us = {1'b1, i_rx_octet[`HRPC_PBO_HI:0]};
            end else begin
                d.pbo_ds = {1'b1, i_rx_octet[`HRPC_PBO_HI:0]};
            end
            d.cnt[{i_rx_dir, 1'b0}] = 3'd0;
            d.cnt[{i_rx_dir, 1'b1}] = 3'd0;
            d.cur = {i_rx_dir, 1'b0};
            d.pos = 2'd0;
            d.jdx = 3'd0;
        end else if (rx_go) begin
            if (set != q.cur) begin
                d.cnt[set] = 3'd0;
            end
            d.cur = set;
            d.pos = rpos + 2'd1;
            d.jdx = rjdx;
            case (rpos)
                2'd0: d.first = i_rx_octet;
                2'd1: d.mn_lo = i_rx_octet[5:0];
                2'd2: d.mx_lo = i_rx_octet[5:0];
                default: begin
                    ev[`HRPC_EV_RNG] = 1'b1;
                    ev[`HRPC_EV_RSV] = drsv;
                    ev[`HRPC_EV_ORD] = dord;
                    if (rjdx < `HRPC_NRNG) begin
                        d.tab[{set, rjdx[1:0]}] = {dstep, dmax, dmin};
                        d.cnt[set] = rjdx + 3'd1;
                        d.jdx = rjdx + 3'd1;
                    end
                end
            endcase
        end

        // encoder sequencer
        case (q.tx_st)
            TX_IDLE: begin
                if (cmd_wr && i_reg_wdata[0]) begin
                    d.tx_st = TX_RATE;
                    d.tx_pos = 2'd0;
                    d.tx_oct = enc_oct(q.tx_rng, 2'd0);
                end else if (cmd_wr && i_reg_wdata[1]) begin
                    d.tx_st = TX_PBO;
                    d.tx_oct = {3'h0, q.tx_pbo};
                end
            end
            TX_RATE: begin
                if (i_tx_ready && q.tx_pos == 2'd3) begin
                    d.tx_st = TX_IDLE;
                    ev[`HRPC_EV_TX] = 1'b1;
                end else if (i_tx_ready) begin
                    d.tx_pos = q.tx_pos + 2'd1;
                    d.tx_oct = enc_oct(q.tx_rng, q.tx_pos + 2'd1);
                end
            end
            TX_PBO: begin
                if (i_tx_ready) begin
                    d.tx_st = TX_IDLE;
                    ev[`HRPC_EV_TX] = 1'b1;
                end
            end
            default: d.tx_st = TX_IDLE;
        endcase

        // sticky status: a new event beats a same-cycle clear
        d.ist = (q.ist & ~clr) | ev;
    end

    // state register
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            q <= '0;
            q.ctl_en <= `HRPC_CTRL_RST;
            q.ien <= `HRPC_IEN_RST;
            q.tx_st <= TX_IDLE;
        end else begin
            q <= d;
        end
    end

    // outputs, data from flops
    assign o_reg_rdata = q.rdat;
    assign o_tx_valid = (q.tx_st != TX_IDLE);
    assign o_tx_param = (q.tx_st == TX_PBO);
    assign o_tx_octet = q.tx_oct;
    assign o_irq = |(q.ist & q.ien);

    // checks on the codec's own behaviour
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_n);

    // reserved backoff selector raises the reserved flag
    a_pbo_rsv_flag:
    assert property (rx_go && i_rx_param && i_rx_octet[5]
        |=> q.ist[`HRPC_EV_RSV] && $stable(q.pbo_ds)
        && $stable(q.pbo_us))
    else $error("reserved backoff not flagged");

    // downstream backoff value kept with its valid bit
    a_ds_pbo_store:
    assert property (rx_go && i_rx_param && !i_rx_octet[5] && !i_rx_dir
        |=> q.pbo_ds == {1'b1, $past(i_rx_octet[4:0])})
    else $error("downstream backoff not stored");

    // upstream backoff value kept with its valid bit
    a_us_pbo_store:
    assert property (rx_go && i_rx_param && !i_rx_octet[5] && i_rx_dir
        |=> q.pbo_us == {1'b1, $past(i_rx_octet[4:0])})
    else $error("upstream backoff not stored");

    // backoff octet empties both rate sets of its direction
    a_pbo_clears_set:
    assert property (rx_go && i_rx_param
        |=> q.cnt[{$past(i_rx_dir), 1'b0}] == 3'd0
        && q.cnt[{$past(i_rx_dir), 1'b1}] == 3'd0 && q.pos == 2'd0)
    else $error("direction sets not restarted");

    // first range octet holds the three msbs in bits 0 to 2
    a_tx_first_oct:
    assert property (q.tx_st == TX_IDLE && cmd_wr && i_reg_wdata[0]
        |=> o_tx_valid && o_tx_octet == {5'h00, q.tx_rng[20],
        q.tx_rng[13], q.tx_rng[6]})
    else $error("first range octet wrong");

    // low-bit octets follow in minimum, maximum, step order
    a_tx_low_oct:
    assert property (q.tx_st == TX_RATE && q.tx_pos == 2'd0 && i_tx_ready
        |=> o_tx_octet == {2'h0, q.tx_rng[5:0]})
    else $error("low rate octet wrong");

    a_tx_max_oct:
    assert property (q.tx_st == TX_RATE && q.tx_pos == 2'd1 && i_tx_ready
        |=> o_tx_octet == {2'h0, q.tx_rng[12:7]})
    else $error("maximum low octet wrong");

    a_tx_step_oct:
    assert property (q.tx_st == TX_RATE && q.tx_pos == 2'd2 && i_tx_ready
        |=> o_tx_octet == {2'h0, q.tx_rng[19:14]})
    else $error("step low octet wrong");

    // a full range stores the 7-bit values of its slot
    a_tab_store:
    assert property (rx_go && !i_rx_param && rpos == 2'd3
        && rjdx < `HRPC_NRNG
        |=> q.tab[{$past(set), $past(rjdx[1:0])}] ==
        {$past(q.first[2]), $past(i_rx_octet[5:0]),
        $past(q.first[1]), $past(q.mx_lo),
        $past(q.first[0]), $past(q.mn_lo)})
    else $error("range not stored");

    // each completed range within the table depth advances the range index by one
    a_range_index:
    assert property (rx_go && !i_rx_param && rpos == 2'd3
        && rjdx < `HRPC_NRNG
        |=> q.jdx == $past(rjdx) + 3'd1 && q.pos == 2'd0
        && q.ist[`HRPC_EV_RNG])
    else $error("range index not advanced");

    // minimum above maximum is flagged
    a_order_flag:
    assert property (rx_go && !i_rx_param && rpos == 2'd3
        && {q.first[0], q.mn_lo} > {q.first[1], q.mx_lo}
        |=> q.ist[`HRPC_EV_ORD])
    else $error("min above max not flagged");

    // reserved first-octet bits do not alter stored values
    a_rsv_ignored:
    assert property (rx_go && !i_rx_param && rpos == 2'd3
        && rjdx == 3'd0
        |=> q.tab[{$past(set), 2'd0}][13:0] ==
        {$past(q.first[1]), $past(q.mx_lo),
        $past(q.first[0]), $past(q.mn_lo)})
    else $error("reserved bits leaked into rates");

    // reserved first-octet bits raise the reserved flag
    a_first_rsv_flag:
    assert property (rx_go && !i_rx_param && rpos == 2'd3
        && |q.first[`HRPC_RSV_HI:`HRPC_RSV_LO]
        |=> q.ist[`HRPC_EV_RSV])
    else $error("reserved range bits not flagged");

    // a range past the table depth is counted out, never stored
    a_beyond_refused:
    assert property (rx_go && !i_rx_param && rpos == 2'd3
        && rjdx >= `HRPC_NRNG
        |=> $stable(q.tab) && q.jdx == $past(rjdx))
    else $error("range beyond the table stored");

    // backoff command sends one parameter octet, selector clear
    a_tx_pbo_oct:
    assert property (q.tx_st == TX_IDLE && cmd_wr && !i_reg_wdata[0]
        && i_reg_wdata[1]
        |=> o_tx_param && o_tx_octet == {3'h0, q.tx_pbo})
    else $error("backoff octet wrong");

    // a stalled octet stays on the line unchanged
    a_tx_stall_hold:
    assert property (o_tx_valid && !i_tx_ready
        |=> $stable(o_tx_octet) && $stable(q.tx_st))
    else $error("stalled octet not held");

    // last range octet accepted ends the frame and flags it
    a_tx_done_flag:
    assert property (q.tx_st == TX_RATE && q.tx_pos == 2'd3 && i_tx_ready
        |=> !o_tx_valid && q.ist[`HRPC_EV_TX])
    else $error("transmit done not flagged");
endmodule
`default_nettype wire

// ---- hdl/hrpc_defs.svh ----
/*
 * constants of the rate parameter codec: register byte offsets,
 * octet field positions, event bits, reset values and table depth.
 * assumes it is included by bare name after the timescale line.
 */
`ifndef HRPC_DEFS_SVH
`define HRPC_DEFS_SVH

// register byte offsets
`define HRPC_A_CTRL 8'h00
`define HRPC_A_STAT 8'h04
`define HRPC_A_CLR 8'h08
`define HRPC_A_IEN 8'h0c
`define HRPC_A_PBO 8'h10
`define HRPC_A_RSEL 8'h14
`define HRPC_A_RRNG 8'h18
`define HRPC_A_TRNG 8'h1c
`define HRPC_A_TPBO 8'h20
`define HRPC_A_TCMD 8'h24

// first rate octet: msb positions and reserved span
`define HRPC_MIN_MSB 0
`define HRPC_MAX_MSB 1
`define HRPC_STP_MSB 2
`define HRPC_RSV_HI 5
`define HRPC_RSV_LO 3

// parameter octet: reserved selector and backoff top bit
`define HRPC_PBO_RSV 5
`define HRPC_PBO_HI 4

// sticky event bits
`define HRPC_EV_RNG 0
`define HRPC_EV_RSV 1
`define HRPC_EV_ORD 2
`define HRPC_EV_TX 3

// reset values
`define HRPC_CTRL_RST 1'b1
`define HRPC_IEN_RST 4'h0

// stored ranges per parameter set
`define HRPC_NRNG 3'h4

`endif

// ---- hdl/hrpc_pkg.sv ----
/*
 * types of the rate parameter codec: transmit states and the
 * packed state record of the top module.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package hrpc_pkg;

    // transmit sequencer states, one-hot
    typedef enum logic [2:0] {
        TX_IDLE = 3'b001,
        TX_RATE = 3'b010,
        TX_PBO = 3'b100
    } hrpc_tx_t;

    // whole state of the codec
    typedef struct packed {
        logic ctl_en;
        logic [3:0] ist;
        logic [3:0] ien;
        logic [3:0] rsel;
        logic [31:0] rdat;
        logic [5:0] pbo_ds;
        logic [5:0] pbo_us;
        logic [1:0] cur;
        logic [1:0] pos;
        logic [2:0] jdx;
        logic [3:0][2:0] cnt;
        logic [7:0] first;
        logic [5:0] mn_lo;
        logic [5:0] mx_lo;
        logic [15:0][20:0] tab;
        logic [20:0] tx_rng;
        logic [4:0] tx_pbo;
        hrpc_tx_t tx_st;
        logic [1:0] tx_pos;
        logic [7:0] tx_oct;
    } hrpc_state_t;

endpackage

// ---- hdl/hrpc_range_dec.sv ----
/*
 * combinational decode of one four-octet rate range into 7-bit
 * minimum, maximum and step, with reserved and order flags.
 * assumes the caller holds the first three octets stable.
 */
`timescale 1ns/1ps
`default_nettype none
`include "hrpc_defs.svh"

module hrpc_range_dec (
    // octets of one range
    input wire logic [7:0] i_first,
    input wire logic [5:0] i_min_lo,
    input wire logic [5:0] i_max_lo,
    input wire logic [5:0] i_step_lo,
    // decoded values
    output logic [6:0] o_min,
    output logic [6:0] o_max,
    output logic [6:0] o_step,
    // checks
    output logic o_rsvd,
    output logic o_order_err
);
    // msb from the first octet, low six from its own octet
    assign o_min = {i_first[`HRPC_MIN_MSB], i_min_lo};
    assign o_max = {i_first[`HRPC_MAX_MSB], i_max_lo};
    assign o_step = {i_first[`HRPC_STP_MSB], i_step_lo};

    // reserved bits only raise a flag, never alter values
    assign o_rsvd = |i_first[`HRPC_RSV_HI:`HRPC_RSV_LO];
    assign o_order_err = (o_min > o_max);
endmodule
`default_nettype wire

// ---- test/hrpc_remote.sv ----
/*
 * remote transceiver model: sends level-3 octets to the codec and
 * takes its transmitted octets with a recurring stall.
 * assumes the codec samples on the rising edge of i_mclk.
 */
`timescale 1ns/1ps
`default_nettype none

module hrpc_remote (
    // clock
    input wire logic i_mclk,
    // octets toward the codec
    output logic o_rx_valid,
    output logic [7:0] o_rx_octet,
    output logic o_rx_param,
    output logic o_rx_dir,
    output logic o_rx_pam32,
    // octets from the codec
    input wire logic i_tx_valid,
    input wire logic [7:0] i_tx_octet,
    output logic o_tx_ready
);
    logic [7:0] got[$];
    logic [1:0] ph = 2'h0;

    // quiet line at time zero
    initial begin
        o_rx_valid = 1'b0;
        o_rx_octet = 8'h00;
        o_rx_param = 1'b0;
        o_rx_dir = 1'b0;
        o_rx_pam32 = 1'b0;
    end

    // one octet per cycle
    task automatic send(input logic [7:0] oc, input logic par,
            input logic dir, input logic p32);
        @(posedge i_mclk);
        o_rx_valid <= 1'b1;
        o_rx_octet <= oc;
        o_rx_param <= par;
        o_rx_dir <= dir;
        o_rx_pam32 <= p32;
    endtask

    // released line shows the inverse of the last octet
    task automatic idle();
        @(posedge i_mclk);
        o_rx_valid <= 1'b0;
        o_rx_octet <= ~o_rx_octet;
    endtask

    // backoff octet goes first in each direction
    task automatic send_pbo(input logic [7:0] oc, input logic dir);
        send(oc, 1'b1, dir, 1'b0);
    endtask

    // msb octet then three low-bit octets
    task automatic send_rng(input logic dir, input logic p32,
            input logic [7:0] f, input logic [7:0] a,
            input logic [7:0] b, input logic [7:0] c);
        send(f, 1'b0, dir, p32);
        send(a, 1'b0, dir, p32);
        send(b, 1'b0, dir, p32);
        send(c, 1'b0, dir, p32);
    endtask

    // accept octets, stall one cycle in four
    always @(posedge i_mclk) begin
        ph <= ph + 2'h1;
        if (i_tx_valid && o_tx_ready) begin
            got.push_back(i_tx_octet);
        end
        o_tx_ready <= (ph != 2'h1);
    end
endmodule

`default_nettype wire

// ---- test/hrpc_codec_test.sv ----
/*
 * self-checking bench of the rate parameter codec: register port,
 * receive decode, interrupt and transmit through the remote model.
 * assumes hrpc_remote and the codec sources are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
`include "hrpc_defs.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin \
error_cnt++; $display("Error at %0t: got %h want %h", $time, a, b); end end

module hrpc_codec_test;
    logic i_mclk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [7:0] i_reg_addr = 8'h00;
    logic [31:0] i_reg_wdata = 32'h0;
    logic i_reg_wr = 1'b0;
    logic i_reg_rd = 1'b0;
    logic [31:0] o_reg_rdata;
    logic rx_v, rx_p, rx_d, rx_m, tx_v, tx_p, tx_r, o_irq;
    logic [7:0] rx_o, tx_o;
    logic [31:0] r;
    int error_cnt = 0;
    int tests_run = 0;

    // 10 MHz clock
    always #50 i_mclk = ~i_mclk;

    hrpc_codec dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
        .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
        .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
        .o_reg_rdata(o_reg_rdata), .i_rx_valid(rx_v),
        .i_rx_octet(rx_o), .i_rx_param(rx_p), .i_rx_dir(rx_d),
        .i_rx_pam32(rx_m), .o_tx_valid(tx_v), .o_tx_octet(tx_o),
        .o_tx_param(tx_p), .i_tx_ready(tx_r), .o_irq(o_irq));

    hrpc_remote remote (.i_mclk(i_mclk), .o_rx_valid(rx_v),
        .o_rx_octet(rx_o), .o_rx_param(rx_p), .o_rx_dir(rx_d),
        .o_rx_pam32(rx_m), .i_tx_valid(tx_v), .i_tx_octet(tx_o),
        .o_tx_ready(tx_r));

    // verdict and end of run
    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // one-cycle register write
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        i_reg_addr <= a;
        i_reg_wdata <= d;
        i_reg_wr <= 1'b1;
        @(posedge i_mclk);
        i_reg_wr <= 1'b0;
    endtask

    // one-cycle read, data in the following cycle
    task automatic rd(input logic [7:0] a);
        @(posedge i_mclk);
        i_reg_addr <= a;
        i_reg_rd <= 1'b1;
        @(posedge i_mclk);
        i_reg_rd <= 1'b0;
        #1 r = o_reg_rdata;
    endtask

    // reset values and refused reads
    task automatic t_reset();
        rd(`HRPC_A_CTRL);
        `CHK(r, 32'h1)
        rd(`HRPC_A_IEN);
        `CHK(r, 32'h0)
        rd(8'h3c);
        `CHK(r, 32'h0)
        rd(`HRPC_A_CLR);
        `CHK(r, 32'h0)
        wr(`HRPC_A_CTRL, 32'h0);
        remote.send_pbo(8'h01, 1'b0);
        remote.idle();
        rd(`HRPC_A_PBO);
        `CHK(r, 32'h0)
        rd(`HRPC_A_STAT);
        `CHK(r, 32'h0)
        wr(`HRPC_A_CTRL, 32'h1);
        $display("t_reset done");
    endtask

    // downstream 32-level range, ignored top bits, min above max
    task automatic t_rx_ds();
        remote.send_pbo(8'hd3, 1'b0);
        remote.send_rng(1'b0, 1'b1, 8'hc5, 8'hca, 8'h7f, 8'h41);
        remote.idle();
        remote.idle();
        rd(`HRPC_A_PBO);
        `CHK(r & 32'h3f, 32'h33)
        wr(`HRPC_A_RSEL, 32'h4);
        rd(`HRPC_A_RRNG);
        `CHK(r, {5'h0, 3'h1, 3'h0, 7'h41, 7'h3f, 7'h4a})
        rd(`HRPC_A_STAT);
        `CHK(r, 32'h5)
        wr(`HRPC_A_RSEL, 32'h0);
        rd(`HRPC_A_RRNG);
        `CHK(r[26:24], 3'h0)
        wr(`HRPC_A_CLR, 32'hf);
        rd(`HRPC_A_STAT);
        `CHK(r, 32'h0)
        $display("t_rx_ds done");
    endtask

    // reserved backoff pattern, masked then enabled interrupt
    task automatic t_rsv_irq();
        remote.send_pbo(8'h25, 1'b1);
        remote.idle();
        remote.idle();
        rd(`HRPC_A_STAT);
        `CHK(r, 32'h2)
        `CHK(o_irq, 1'b0)
        rd(`HRPC_A_PBO);
        `CHK(r[13], 1'b0)
        wr(`HRPC_A_IEN, 32'h2);
        #1 `CHK(o_irq, 1'b1)
        wr(`HRPC_A_CLR, 32'h2);
        #1 `CHK(o_irq, 1'b0)
        $display("t_rsv_irq done");
    endtask

    // upstream 16-level set filled past its depth, reserved bits set
    task automatic t_ext_us();
        remote.send_pbo(8'h07, 1'b1);
        remote.send_rng(1'b1, 1'b0, 8'h3a, 8'h01, 8'h02, 8'h03);
        remote.send_rng(1'b1, 1'b0, 8'h00, 8'h05, 8'h06, 8'h07);
        // two more fill the set, the last one is refused
        repeat (3) remote.send_rng(1'b1, 1'b0, 8'h00, 8'h01, 8'h02, 8'h03);
        remote.idle();
        remote.idle();
        rd(`HRPC_A_PBO);
        `CHK(r[13:8], 6'h27)
        rd(`HRPC_A_STAT);
        `CHK(r, 32'h3)
        wr(`HRPC_A_RSEL, 32'h8);
        rd(`HRPC_A_RRNG);
        `CHK(r, {5'h0, 3'h4, 3'h0, 7'h03, 7'h42, 7'h01})
        wr(`HRPC_A_RSEL, 32'h9);
        rd(`HRPC_A_RRNG);
        `CHK(r, {5'h0, 3'h4, 3'h0, 7'h07, 7'h06, 7'h05})
        $display("t_ext_us done");
    endtask

    // encode a range with stalls, busy command refused, then backoff
    task automatic t_tx();
        int n;
        wr(`HRPC_A_CLR, 32'hf);
        wr(`HRPC_A_TRNG, {11'h0, 7'h7f, 7'h12, 7'h45});
        wr(`HRPC_A_TCMD, 32'h1);
        #1 `CHK({tx_v, tx_p}, 2'b10)
        wr(`HRPC_A_TCMD, 32'h2);
        for (n = 0; n < 40 && remote.got.size() < 4; n++) begin
            @(posedge i_mclk);
        end
        repeat (8) @(posedge i_mclk);
        `CHK(remote.got.size(), 4)
        if (remote.got.size() == 4) begin
            `CHK(remote.got[0], 8'h05)
            `CHK(remote.got[1], 8'h05)
            `CHK(remote.got[2], 8'h12)
            `CHK(remote.got[3], 8'h3f)
        end
        rd(`HRPC_A_STAT);
        `CHK(r[3], 1'b1)
        wr(`HRPC_A_TPBO, 32'h11);
        wr(`HRPC_A_TCMD, 32'h2);
        #1 `CHK({tx_v, tx_p}, 2'b11)
        for (n = 0; n < 40 && remote.got.size() < 5; n++) begin
            @(posedge i_mclk);
        end
        if (n == 40) begin
            error_cnt++;
        end else begin
            `CHK(remote.got[4], 8'h11)
        end
        #1 `CHK(tx_v, 1'b0)
        $display("t_tx done");
    endtask

    // main sequence
    initial begin
        repeat (2) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        t_reset();
        t_rx_ds();
        t_rsv_irq();
        t_ext_us();
        t_tx();
        print_verdict();
    end
endmodule

`default_nettype wire
